// ### rfsw_map.svh
// constants and bit positions for the frame and sleep/wake block
// Behaviour
// RULE_01: relayed send data leaves with receive code
// RULE_02: first payload byte names originating node
// RULE_03: payload length one byte to fifty kilobytes
// RULE_04: root takes all; others take root only
// RULE_05: two all-ones filler bytes precede frame
// RULE_06: host hunts start byte, clears position
// RULE_07: length sent low byte then high byte
// RULE_08: host checks command code against receive
// RULE_09: host latches address, stores payload bytes
// RULE_10: host eats checksum and end, resyncs
// RULE_11: sleep code, ten bytes, first picks period
// RULE_12: period code table, others mean 500ms
// RULE_13: sleep only via root, root floods it
// RULE_14: node sleeps about 500ms after message
// RULE_15: asleep means all hardware powered down
// RULE_16: period over, listen about three milliseconds
// RULE_17: no wakeup heard, sleep another period
// RULE_18: wakeup code, ignored payload, root floods
// RULE_19: root repeats wakeup, count from period
// RULE_20: wakeup heard while listening ends sleep
// RULE_21: host drops frame on unexpected code
`ifndef RFSW_MAP_SVH
`define RFSW_MAP_SVH
`define RFSW_CMD_SEND    8'h25
`define RFSW_CMD_RECV    8'h26
`define RFSW_CMD_SLEEP   8'h21
`define RFSW_CMD_WAKE    8'h22
`define RFSW_START_BYTE  8'h02
`define RFSW_END_BYTE    8'h03
`define RFSW_FILL_BYTE   8'hff
`define RFSW_ROOT_ADDR   8'h01
`define RFSW_LEN_MAX     16'hc800
`define RFSW_CLK_KHZ     25000
`define RFSW_SLEEP_DLY_MS 500
`define RFSW_LISTEN_MS   3
`define RFSW_WAKE_GAP_MS 2
`define RFSW_PER0_MS     16'h0064
`define RFSW_PER1_MS     16'h00c8
`define RFSW_PER2_MS     16'h01f4
`define RFSW_PER3_MS     16'h03e8
`define RFSW_PER4_MS     16'h07d0
`define RFSW_PER5_MS     16'h1388
`define RFSW_PER6_MS     16'h2710
`define RFSW_PER_DFLT_MS `RFSW_PER2_MS
`define RFSW_OFS_CTRL    8'h00
`define RFSW_OFS_STATUS  8'h04
`define RFSW_OFS_DROPS   8'h08
`define RFSW_OFS_PERIOD  8'h0c
`define RFSW_CTRL_ROOT   0
`endif

// ### rfsw_pkg.sv
// types shared by the frame and sleep/wake block
package rfsw_pkg;
    // frame emitter states, one-hot
    typedef enum logic [4:0] {
        FRM_IDLE = 5'h01,
        FRM_HEAD = 5'h02,
        FRM_DATA = 5'h04,
        FRM_TAIL = 5'h08,
        FRM_DROP = 5'h10
    } rfsw_frm_t;
    // node power states, one-hot
    typedef enum logic [3:0] {
        SLP_AWAKE  = 4'h1,
        SLP_ARMED  = 4'h2,
        SLP_ASLEEP = 4'h4,
        SLP_LISTEN = 4'h8
    } rfsw_slp_t;
    // header of a payload arriving from the network
    typedef struct packed {
        logic [7:0]  cmd;
        logic [7:0]  src;
        logic [15:0] len;
    } rfsw_hdr_t;
    // parsed host command, only first data byte kept
    typedef struct packed {
        logic [7:0] code;
        logic [7:0] arg;
    } rfsw_cmd_t;
endpackage

// ### rfsw_core.sv
// received-data framer and sleep/wake controller
`timescale 1ns/10ps
`include "rfsw_map.svh"
module rfsw_core import rfsw_pkg::*; #(
    parameter int unsigned CYC_PER_MS = `RFSW_CLK_KHZ
) (
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        net_hdr_valid,
    input  rfsw_hdr_t        net_hdr,
    output logic             net_hdr_ready,
    input  wire logic        net_data_valid,
    input  wire logic [7:0]  net_data,
    output logic             net_data_ready,
    output logic             tx_valid,
    output logic      [7:0]  tx_byte,
    input  wire logic        tx_ready,
    input  wire logic        host_cmd_valid,
    input  rfsw_cmd_t        host_cmd,
    input  wire logic        net_sleep,
    input  wire logic [7:0]  net_sleep_code,
    input  wire logic        net_wake,
    output logic             flood_sleep,
    output logic      [7:0]  flood_code,
    output logic             flood_wake,
    output logic             power_down,
    output logic             listen
);
    localparam int unsigned DLY_CYC = `RFSW_SLEEP_DLY_MS * CYC_PER_MS;
    localparam int unsigned LSN_CYC = `RFSW_LISTEN_MS * CYC_PER_MS;
    localparam int unsigned GAP_CYC = `RFSW_WAKE_GAP_MS * CYC_PER_MS;

    rfsw_frm_t   frm_reg;        // frame emitter state
    rfsw_slp_t   slp_reg;        // node power state
    logic [2:0]  idx_reg;        // byte index in head or tail
    logic [15:0] rem_reg;        // payload bytes still to come
    logic [15:0] sum_reg;        // running payload checksum
    logic [15:0] len_reg;        // latched length field
    logic [7:0]  src_reg;        // latched originator address
    logic [31:0] ctrl_reg;       // control word
    logic [7:0]  drop_reg;       // refused frame count
    logic [7:0]  code_reg;       // node sleep period code
    logic [7:0]  root_code_reg;  // last period flooded by root
    logic [31:0] tmr_reg;        // power state timer
    logic [15:0] wake_left_reg;  // wakeup copies still to send
    logic [31:0] gap_reg;        // spacing between copies
    logic        is_root;        // this node is the root
    logic        slot_free;      // output byte slot free next cycle
    logic        hdr_take;       // header handshake
    logic        hdr_ok;         // header passes all filters
    logic [31:0] rd_next;        // read mux result

    // sleep period in ms per code
    function automatic logic [15:0] period_ms(input logic [7:0] c);
        case (c)
            8'h00:   period_ms = `RFSW_PER0_MS;
            8'h01:   period_ms = `RFSW_PER1_MS;
            8'h02:   period_ms = `RFSW_PER2_MS;
            8'h03:   period_ms = `RFSW_PER3_MS;
            8'h04:   period_ms = `RFSW_PER4_MS;
            8'h05:   period_ms = `RFSW_PER5_MS;
            8'h06:   period_ms = `RFSW_PER6_MS;
            default: period_ms = `RFSW_PER_DFLT_MS; // [RULE_12]
        endcase
    endfunction

    // sleep period in clock cycles, minus one for the timer load
    function automatic logic [31:0] period_load(input logic [7:0] c);
        period_load = 32'(32'(period_ms(c)) * CYC_PER_MS - 1);
    endfunction

    // head bytes: fill, fill, start, length, code, originator
    function automatic logic [7:0] head_byte(input logic [2:0] i, input logic [15:0] l,
                                             input logic [7:0] s);
        case (i)
            3'h0, 3'h1: head_byte = `RFSW_FILL_BYTE;  // [RULE_05]
            3'h2:       head_byte = `RFSW_START_BYTE;
            3'h3:       head_byte = l[7:0];           // [RULE_07]
            3'h4:       head_byte = l[15:8];          // [RULE_07]
            3'h5:       head_byte = `RFSW_CMD_RECV;   // [RULE_01]
            default:    head_byte = s;                // [RULE_02]
        endcase
    endfunction

    assign is_root   = ctrl_reg[`RFSW_CTRL_ROOT];
    assign slot_free = !tx_valid || tx_ready;
    assign hdr_take  = (frm_reg == FRM_IDLE) && net_hdr_valid && net_hdr_ready;
    // only relayed send data, sane length, allowed origin
    assign hdr_ok = (net_hdr.cmd == `RFSW_CMD_SEND)                         // [RULE_01]
                 && (net_hdr.len != 16'h0000) && (net_hdr.len <= `RFSW_LEN_MAX) // [RULE_03]
                 && (is_root || net_hdr.src == `RFSW_ROOT_ADDR);               // [RULE_04]

    // frame emitter and output byte slot
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            frm_reg        <= FRM_IDLE;
            idx_reg        <= 3'h0;
            rem_reg        <= 16'h0000;
            sum_reg        <= 16'h0000;
            len_reg        <= 16'h0000;
            src_reg        <= 8'h00;
            tx_valid       <= 1'b0;
            tx_byte        <= 8'h00;
            net_hdr_ready  <= 1'b0;
            net_data_ready <= 1'b0;
        end else begin
            // taken byte leaves the slot unless reloaded below
            if (tx_ready) begin
                tx_valid <= 1'b0;
            end
            case (frm_reg)
                FRM_IDLE: begin
                    net_hdr_ready <= 1'b1;
                    if (hdr_take) begin
                        net_hdr_ready <= 1'b0;
                        len_reg       <= net_hdr.len;
                        src_reg       <= net_hdr.src;
                        rem_reg       <= net_hdr.len - 16'h0001;
                        sum_reg       <= {8'h00, net_hdr.src};
                        idx_reg       <= 3'h0;
                        if (hdr_ok) begin
                            frm_reg <= FRM_HEAD;
                        end else if (net_hdr.len > 16'h0001) begin
                            // refused payload is still drained to free the source
                            frm_reg        <= FRM_DROP;
                            net_data_ready <= 1'b1;
                        end
                    end
                end
                FRM_HEAD: begin
                    if (slot_free) begin
                        tx_valid <= 1'b1;
                        tx_byte  <= head_byte(idx_reg, len_reg, src_reg);
                        idx_reg  <= idx_reg + 3'h1;
                        if (idx_reg == 3'h6) begin
                            idx_reg <= 3'h0;
                            frm_reg <= (rem_reg == 16'h0000) ? FRM_TAIL : FRM_DATA;
                        end
                    end
                end
                FRM_DATA: begin
                    // one byte per slot; throughput is far above any uart rate
                    if (net_data_valid && net_data_ready) begin
                        tx_valid       <= 1'b1;
                        tx_byte        <= net_data;
                        sum_reg        <= sum_reg + {8'h00, net_data};
                        rem_reg        <= rem_reg - 16'h0001;
                        net_data_ready <= 1'b0;
                        if (rem_reg == 16'h0001) begin
                            frm_reg <= FRM_TAIL;
                        end
                    end else begin
                        net_data_ready <= slot_free;
                    end
                end
                FRM_TAIL: begin
                    // checksum low, high, then end byte
                    if (slot_free) begin
                        tx_valid <= 1'b1;
                        idx_reg  <= idx_reg + 3'h1;
                        case (idx_reg)
                            3'h0:    tx_byte <= sum_reg[7:0];
                            3'h1:    tx_byte <= sum_reg[15:8];
                            default: tx_byte <= `RFSW_END_BYTE;
                        endcase
                        if (idx_reg == 3'h2) begin
                            idx_reg <= 3'h0;
                            frm_reg <= FRM_IDLE;
                        end
                    end
                end
                FRM_DROP: begin
                    if (net_data_valid) begin
                        rem_reg <= rem_reg - 16'h0001;
                        if (rem_reg == 16'h0001) begin
                            net_data_ready <= 1'b0;
                            frm_reg        <= FRM_IDLE;
                        end
                    end
                end
                default: frm_reg <= FRM_IDLE;
            endcase
        end
    end

    // node power cycle; the root stays awake to serve its host
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            slp_reg    <= SLP_AWAKE;
            tmr_reg    <= 32'h0000_0000;
            code_reg   <= 8'h00;
            power_down <= 1'b0;
            listen     <= 1'b0;
        end else begin
            case (slp_reg)
                SLP_AWAKE: begin
                    if (net_sleep && !is_root) begin
                        slp_reg  <= SLP_ARMED;
                        code_reg <= net_sleep_code;
                        tmr_reg  <= 32'(DLY_CYC - 1);   // [RULE_14]
                    end
                end
                SLP_ARMED: begin
                    tmr_reg <= tmr_reg - 32'h1;
                    if (tmr_reg == 32'h0) begin
                        slp_reg    <= SLP_ASLEEP;
                        power_down <= 1'b1;             // [RULE_15]
                        tmr_reg    <= period_load(code_reg);
                    end
                end
                SLP_ASLEEP: begin
                    // wakeup traffic is not heard while powered down
                    tmr_reg <= tmr_reg - 32'h1;
                    if (tmr_reg == 32'h0) begin
                        slp_reg    <= SLP_LISTEN;
                        power_down <= 1'b0;
                        listen     <= 1'b1;             // [RULE_16]
                        tmr_reg    <= 32'(LSN_CYC - 1);
                    end
                end
                SLP_LISTEN: begin
                    tmr_reg <= tmr_reg - 32'h1;
                    if (net_wake) begin
                        slp_reg <= SLP_AWAKE;           // [RULE_20]
                        listen  <= 1'b0;
                    end else if (tmr_reg == 32'h0) begin
                        slp_reg    <= SLP_ASLEEP;       // [RULE_17]
                        listen     <= 1'b0;
                        power_down <= 1'b1;
                        tmr_reg    <= period_load(code_reg);
                    end
                end
                default: slp_reg <= SLP_AWAKE;
            endcase
        end
    end

    // root flooding of sleep and repeated wakeup
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            flood_sleep   <= 1'b0;
            flood_wake    <= 1'b0;
            flood_code    <= 8'h00;
            root_code_reg <= 8'h00;
            wake_left_reg <= 16'h0000;
            gap_reg       <= 32'h0000_0000;
        end else begin
            flood_sleep <= 1'b0;
            flood_wake  <= 1'b0;
            // host commands count only at the root
            if (host_cmd_valid && is_root && host_cmd.code == `RFSW_CMD_SLEEP) begin
                flood_sleep   <= 1'b1;                  // [RULE_13]
                flood_code    <= host_cmd.arg;          // [RULE_11]
                root_code_reg <= host_cmd.arg;
            end else if (host_cmd_valid && is_root && host_cmd.code == `RFSW_CMD_WAKE) begin
                // copies every gap, enough to span one period plus a window
                wake_left_reg <= period_ms(root_code_reg) / 16'(`RFSW_WAKE_GAP_MS) + 16'h2; // [RULE_19]
                gap_reg       <= 32'h0;                 // [RULE_18]
            end else if (wake_left_reg != 16'h0000) begin
                gap_reg <= gap_reg - 32'h1;
                if (gap_reg == 32'h0) begin
                    flood_wake    <= 1'b1;
                    wake_left_reg <= wake_left_reg - 16'h0001;
                    gap_reg       <= 32'(GAP_CYC - 1);
                end
            end
        end
    end

    // register read mux; unmapped offsets read zero
    always_comb begin
        case (reg_addr)
            `RFSW_OFS_CTRL:   rd_next = ctrl_reg;
            `RFSW_OFS_STATUS: rd_next = {23'h0, slp_reg, frm_reg};
            `RFSW_OFS_DROPS:  rd_next = {24'h0, drop_reg};
            `RFSW_OFS_PERIOD: rd_next = {24'h0, code_reg};
            default:          rd_next = 32'h0000_0000;
        endcase
    end

    // register writes, read data and refused frame counter
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_reg  <= 32'h0000_0000;
            drop_reg  <= 8'h00;
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= reg_rd ? rd_next : 32'h0000_0000;
            if (reg_wr && reg_addr == `RFSW_OFS_CTRL) begin
                ctrl_reg <= {31'h0, reg_wdata[`RFSW_CTRL_ROOT]};
            end
            // a refusal in the clearing cycle still counts
            if (hdr_take && !hdr_ok) begin
                drop_reg <= drop_reg + 8'h01;
            end else if (reg_wr && reg_addr == `RFSW_OFS_DROPS) begin
                drop_reg <= 8'h00;
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    sequence s_hdr_good;
        hdr_take && hdr_ok;
    endsequence
    sequence s_window_lapsed;
        slp_reg == SLP_LISTEN && tmr_reg == 32'h0 && !net_wake;
    endsequence

    AST_FILL_LEADS: assert property ( // [RULE_05]
        s_hdr_good |-> ##2 (tx_valid && tx_byte == `RFSW_FILL_BYTE))
        else $error("frame did not open with filler");
    AST_RECV_CODE: assert property ( // [RULE_01]
        (frm_reg == FRM_HEAD && idx_reg == 3'h6 && tx_valid) |-> tx_byte == `RFSW_CMD_RECV)
        else $error("command byte is not receive code");
    AST_SRC_FIRST: assert property ( // [RULE_02]
        ($past(frm_reg) == FRM_HEAD && frm_reg != FRM_HEAD) |-> (tx_valid && tx_byte == src_reg))
        else $error("first payload byte is not originator");
    AST_LEN_RANGE: assert property ( // [RULE_03]
        (hdr_take && (net_hdr.len == 16'h0 || net_hdr.len > `RFSW_LEN_MAX)) |=> frm_reg != FRM_HEAD)
        else $error("bad length accepted");
    AST_ORIGIN: assert property ( // [RULE_04]
        (hdr_take && !is_root && net_hdr.src != `RFSW_ROOT_ADDR) |=> frm_reg != FRM_HEAD)
        else $error("non-root origin accepted by node");
    AST_SLEEP_ENTRY: assert property ( // [RULE_14]
        (slp_reg == SLP_ARMED && tmr_reg == 32'h0) |=> (slp_reg == SLP_ASLEEP && power_down && !listen))
        else $error("sleep not entered after delay");
    AST_LISTEN_OPEN: assert property ( // [RULE_16]
        (slp_reg == SLP_ASLEEP && tmr_reg == 32'h0) |=> (listen && !power_down && tmr_reg == 32'(LSN_CYC - 1)))
        else $error("listen window not opened");
    AST_RESLEEP: assert property ( // [RULE_17]
        s_window_lapsed |=> (power_down && !listen && tmr_reg == period_load(code_reg)))
        else $error("node did not resleep");
    AST_WAKE_HEARD: assert property ( // [RULE_20]
        (slp_reg == SLP_LISTEN && net_wake) |=> (slp_reg == SLP_AWAKE && !listen && !power_down))
        else $error("wakeup ignored in window");
    AST_ROOT_ONLY: assert property ( // [RULE_13]
        (host_cmd_valid && !is_root) |=> !flood_sleep)
        else $error("non-root flooded sleep");
endmodule

// ### rfsw_host.sv
// host-side receiver model that takes and parses frames from the block
`timescale 1ns/10ps
module rfsw_host (
    input  wire logic       clock,
    input  wire logic       arst_n,
    input  wire logic       slow,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_byte,
    output logic            tx_ready
);
    logic        synced = 1'b0; // start byte found
    int          pos = 0;       // byte position after start
    int          fills = 0;     // run of filler bytes
    int          got_fills = 0; // fillers seen before last start
    int          frames = 0;    // frames completed
    logic [15:0] len;           // rebuilt length
    logic [7:0]  cmd;           // command code seen
    logic [7:0]  src;           // originator address
    logic [7:0]  endb;          // closing byte
    logic [7:0]  data [0:15];   // payload, index 1 is first user byte

    // ready stalls every other cycle when slow, like a busy uart
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            tx_ready <= 1'b0;
        end else begin
            tx_ready <= slow ? ~tx_ready : 1'b1;
        end
    end

    // parse each byte as it is taken
    always @(posedge clock) begin
        if (arst_n && tx_valid && tx_ready) begin
            if (!synced) begin
                if (tx_byte == 8'h02) begin
                    synced = 1'b1;
                    pos = 0;
                    got_fills = fills;
                end
                fills = (tx_byte == 8'hff) ? fills + 1 : 0;
            end else begin
                if (pos == 0) len[7:0] = tx_byte;
                else if (pos == 1) len[15:8] = tx_byte;
                else if (pos == 2) begin
                    cmd = tx_byte;
                    // other codes abandon the frame unstored
                    if (tx_byte != 8'h26) synced = 1'b0;
                end
                else if (pos == 3) src = tx_byte;
                else if (pos <= len + 2) data[(pos - 3) & 15] = tx_byte;
                else if (pos == len + 5) begin
                    endb = tx_byte;
                    synced = 1'b0;
                    frames++;
                end
                pos++;
            end
        end
    end
endmodule

// ### rfsw_core_test.sv
// self-checking bench for the frame and sleep/wake block
`timescale 1ns/10ps
`include "rfsw_map.svh"
module rfsw_core_test import rfsw_pkg::*;;
    localparam int CPM = 2; // short millisecond keeps the run brief
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00, net_data = 8'h00, tx_byte, flood_code, net_sleep_code = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
    logic reg_wr = 0, reg_rd = 0, net_hdr_valid = 0, net_hdr_ready, net_data_valid = 0, net_data_ready;
    logic tx_valid, tx_ready, host_cmd_valid = 0, net_sleep = 0, net_wake = 0, slow = 0;
    logic flood_sleep, flood_wake, power_down, listen;
    rfsw_hdr_t net_hdr = '0;
    rfsw_cmd_t host_cmd = '0;
    logic [7:0] pay [0:15]; // payload, index 0 unused; the address byte goes in the header as s
    int fail_count = 0, tests_run = 0, cycles = 0, n;
    int ms_tab [8] = '{100, 200, 500, 1000, 2000, 5000, 10000, 500};

    always #20 clock = ~clock;

    rfsw_core #(.CYC_PER_MS(CPM)) u_rfsw_core (.clock(clock), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .net_hdr_valid(net_hdr_valid), .net_hdr(net_hdr), .net_hdr_ready(net_hdr_ready),
        .net_data_valid(net_data_valid), .net_data(net_data), .net_data_ready(net_data_ready),
        .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready), .host_cmd_valid(host_cmd_valid),
        .host_cmd(host_cmd), .net_sleep(net_sleep), .net_sleep_code(net_sleep_code), .net_wake(net_wake),
        .flood_sleep(flood_sleep), .flood_code(flood_code), .flood_wake(flood_wake),
        .power_down(power_down), .listen(listen));
    rfsw_host u_rfsw_host (.clock(clock), .arst_n(arst_n), .slow(slow), .tx_valid(tx_valid),
        .tx_byte(tx_byte), .tx_ready(tx_ready));

    task automatic end_of_test;
        if (fail_count == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // hang guard, well above the longest sleep sweep
    always @(posedge clock) begin
        cycles++;
        if (cycles == 90000) begin
            fail_count++;
            end_of_test();
        end
    end
    task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(posedge clock);
        v = reg_rdata;
    endtask
    // header held until taken, then len-1 bytes each held until taken
    task automatic send(input logic [7:0] c, input logic [7:0] s, input logic [15:0] len);
        @(posedge clock);
        net_hdr_valid <= 1'b1;
        net_hdr <= {c, s, len};
        do @(posedge clock); while (!net_hdr_ready);
        net_hdr_valid <= 1'b0;
        for (int i = 1; i < len; i++) begin
            net_data_valid <= 1'b1;
            net_data <= pay[i];
            do @(posedge clock); while (!net_data_ready);
        end
        net_data_valid <= 1'b0;
    endtask
    task automatic frame_case(input logic [7:0] s, input logic [15:0] len, input int nf);
        send(`RFSW_CMD_SEND, s, len);
        while (u_rfsw_host.frames != nf) @(posedge clock);
        check(u_rfsw_host.got_fills, 2);
        check(u_rfsw_host.len, len);
        check(u_rfsw_host.cmd, 8'h26);
        check(u_rfsw_host.src, s);
        for (int i = 1; i < len; i++) check(u_rfsw_host.data[i], pay[i]);
        check(u_rfsw_host.endb, 8'h03);
    endtask
    task automatic host(input logic [7:0] c, input logic [7:0] a);
        @(posedge clock);
        host_cmd_valid <= 1'b1;
        host_cmd <= {c, a};
        @(posedge clock);
        host_cmd_valid <= 1'b0;
    endtask
    // wake heard in the armed delay must be ignored
    task automatic nap(input logic [7:0] c, input int again);
        @(posedge clock);
        net_sleep <= 1'b1;
        net_sleep_code <= c;
        @(posedge clock);
        net_sleep <= 1'b0;
        net_wake <= 1'b1;
        @(posedge clock);
        net_wake <= 1'b0;
        n = 1;
        do begin @(posedge clock); #1; n++; end while (!power_down && n < 2000);
        check(n, 500 * CPM);
        for (int k = 0; k <= again; k++) begin
            n = 0;
            while (power_down) begin @(posedge clock); #1; n++; end
            check(n, ms_tab[c] * CPM);
            check(listen, 1'b1);
            if (k < again) begin
                n = 0;
                while (listen) begin @(posedge clock); #1; n++; end
                check(n, 3 * CPM);
            end
        end
        @(posedge clock);
        net_wake <= 1'b1;
        @(posedge clock);
        net_wake <= 1'b0;
        repeat (8) @(posedge clock);
        check({power_down, listen}, 2'b00);
        reg_read(`RFSW_OFS_PERIOD, d);
        check(d, {24'h0, c});
    endtask

    initial begin
        for (int i = 0; i < 16; i++) pay[i] = 8'h30 + 8'(i);
        repeat (8) @(posedge clock);
        arst_n <= 1'b1;
        reg_read(`RFSW_OFS_STATUS, d);
        check(d, 32'h21);
        reg_read(8'h10, d);
        check(d, 32'h0);
        // non-root node: only frames from the root pass
        send(`RFSW_CMD_SEND, 8'h03, 16'h0002);
        send(8'h24, 8'h01, 16'h0002);
        send(`RFSW_CMD_SEND, 8'h01, 16'h0000);
        repeat (20) @(posedge clock);
        reg_read(`RFSW_OFS_DROPS, d);
        check(d, 32'h3);
        check(u_rfsw_host.frames, 0);
        frame_case(8'h01, 16'h0001, 1);
        reg_write(`RFSW_OFS_DROPS, 32'h0);
        reg_read(`RFSW_OFS_DROPS, d);
        check(d, 32'h0);
        // root takes any node, host stalling
        reg_write(`RFSW_OFS_CTRL, 32'h1);
        slow <= 1'b1;
        {pay[1], pay[2], pay[3], pay[4], pay[5]} = 40'h02_05_74_23_72;
        frame_case(8'h03, 16'h0006, 2);
        host(`RFSW_CMD_SLEEP, 8'h07);
        #1;
        n = 0;
        while (!flood_sleep && n < 8) begin @(posedge clock); #1; n++; end
        check({flood_sleep, flood_code}, 9'h107);
        nap_root_ignore: begin
            @(posedge clock);
            net_sleep <= 1'b1;
            @(posedge clock);
            net_sleep <= 1'b0;
        end
        host(`RFSW_CMD_WAKE, 8'h00);
        n = 0;
        repeat (1100) begin @(posedge clock); #1; n += int'(flood_wake); end
        check(n, 500 / 2 + 2);
        check(power_down, 1'b0);
        // node sleep cycle for every period code
        reg_write(`RFSW_OFS_CTRL, 32'h0);
        // a plain node must not flood on a host command
        host(`RFSW_CMD_SLEEP, 8'h01);
        #1;
        check(flood_sleep, 1'b0);
        for (int c = 0; c < 8; c++) nap(8'(c), (c == 0) ? 1 : 0);
        end_of_test();
    end
endmodule
